// ---- acc_regs.svh ----
// register offsets, field positions, reset values and timing for the comparator control
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define ACC_CH0_CTRL_OFF 16'hF920
`define ACC_CH0_MODE_OFF 16'hF922
`define ACC_CH1_CTRL_OFF 16'hF928
`define ACC_CH1_MODE_OFF 16'hF92A
`define ACC_CTRL_RST 8'h00
`define ACC_MODE_RST 16'h0000

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACC_CTRL_EN_BIT 0
`define ACC_CTRL_D_BIT 1
`define ACC_CTRL_RF_BIT 2
`define ACC_MODE_COND_LSB 0
`define ACC_MODE_FSEL_LSB 4
`define ACC_MODE_SMP_LSB 8
`define ACC_MODE_CK_BIT 12

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ACC_CLK_NS 20
`define ACC_LS_PHI_NS 30518
`define ACC_LS_FILT_NS 61000
`define ACC_HS64_NS 4000
`define ACC_HS128_NS 8000
`define ACC_LS_PHI_CYC ((`ACC_LS_PHI_NS) / (`ACC_CLK_NS))
`define ACC_LS_FILT_CYC ((`ACC_LS_FILT_NS) / (`ACC_CLK_NS))
`define ACC_HS64_CYC ((`ACC_HS64_NS) / (`ACC_CLK_NS))
`define ACC_HS128_CYC ((`ACC_HS128_NS) / (`ACC_CLK_NS))
`define ACC_TRDY_LS_NF 3'h2
`define ACC_TRDY_LS_F 3'h3
`define ACC_TRDY_HS_NF 3'h3
`define ACC_TRDY_HS64 3'h4
`define ACC_TRDY_HS128 3'h3

`endif

// ---- acc_pkg.sv ----
// types for the comparator control
package acc_pkg;
   typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT_RDY, ACC_MEASURE, ACC_WAIT_END} acc_state_t;
   typedef logic [15:0] acc_word_t;
endpackage : acc_pkg

// ---- acc_filt_if.sv ----
// link between a channel and its clock and filter stage
`timescale 1ns/1ns
interface acc_filt_if;
   logic clk_sel;
   logic [1:0] smp_sel;
   logic stop_mode;
   logic restart;
   logic phi_tick;
   logic filt_on;
   logic filt_out;
   modport chan (output clk_sel, output smp_sel, output stop_mode, output restart,
      input phi_tick, input filt_on, input filt_out);
   modport filt (input clk_sel, input smp_sel, input stop_mode, input restart,
      output phi_tick, output filt_on, output filt_out);
endinterface : acc_filt_if

// ---- acc_filter.sv ----
// operating clock tick, input synchroniser and sampling filter of one channel
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_filter
   import acc_pkg::*;
#(
   parameter int CNT_W = 12
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // raw comparator output
   input wire logic analog_compare_out,
   // channel side
   acc_filt_if.filt fif
);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   if (CNT_W < 12 || CNT_W > 16)
   begin : g_chk
      $error("acc_filter: CNT_W must be 12 to 16");
   end

   localparam logic [CNT_W-1:0] LS_PHI = CNT_W'(`ACC_LS_PHI_CYC);
   localparam logic [CNT_W-1:0] LS_FILT = CNT_W'(`ACC_LS_FILT_CYC);
   localparam logic [CNT_W-1:0] HS64 = CNT_W'(`ACC_HS64_CYC);
   localparam logic [CNT_W-1:0] HS128 = CNT_W'(`ACC_HS128_CYC);

   logic [CNT_W-1:0] div_reg;
   logic [CNT_W-1:0] period;
   logic sync1_reg;
   logic sync2_reg;
   logic samp_reg;
   logic out_reg;
   wire ls_filt;
   wire hs_filt;
   wire tick;

   // ---------------------------------------------------------------
   // rate selection
   // ---------------------------------------------------------------
   assign ls_filt = !fif.clk_sel && fif.smp_sel[0];
   assign hs_filt = fif.clk_sel && fif.smp_sel[1];
   assign fif.filt_on = (ls_filt || hs_filt) && !fif.stop_mode;
   assign period = !fif.clk_sel ? (fif.filt_on ? LS_FILT : LS_PHI)
      : ((fif.filt_on && fif.smp_sel[0]) ? HS128 : HS64);
   assign tick = (div_reg == period - CNT_W'(1));
   assign fif.phi_tick = tick && !fif.restart;
   assign fif.filt_out = out_reg;

   // ---------------------------------------------------------------
   // divider
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= '0;
      else if (fif.restart || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + CNT_W'(1);
   end

   // ---------------------------------------------------------------
   // synchroniser and filter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         samp_reg <= 1'b0;
         out_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= analog_compare_out;
         sync2_reg <= sync1_reg;
         if (!fif.filt_on)
            out_reg <= sync2_reg;
         else if (fif.phi_tick)
         begin
            samp_reg <= sync2_reg;
            if (samp_reg == sync2_reg)
               out_reg <= sync2_reg;
         end
      end
   end
endmodule : acc_filter

// ---- acc_top.sv ----
// two channel analog comparator control with register port
//
// Operation
// - control bit 0 starts, stops, shows measurement
// - bit 1 reads comparator result, resets 0
// - result kept when measurement stops
// - valid flag low until result valid
// - mode bits 5:4 pick single, monitor, supervisor
// - single mode: one compare, conditional interrupt, stop
// - single mode condition bit 1 selects level
// - monitor mode: always interrupt, then stop
// - supervisor condition 00 gives no interrupt
// - supervisor 01: interrupt on low or fall
// - supervisor 10: interrupt on high or rise
// - supervisor 11: high at start, both edges
// - supervisor runs until software stops it
// - bit 12 clock select, low speed filter
// - stop mode disables filtering
// - trigger follows condition, valid in supervisor only
// - supervisor valid flag after ready delay
// - single modes clear enable after end delay
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_top
   import acc_pkg::*;
#(
   parameter int CNT_W = 12
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // system state
   input wire logic stop_mode,
   // comparator cores
   input wire logic [1:0] analog_compare_out,
   // events
   output logic [1:0] judge_irq,
   output logic [1:0] trigger_out
);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   if (CNT_W < 12 || CNT_W > 16)
   begin : g_chk
      $error("acc_top: CNT_W must be 12 to 16");
   end

   if (`ACC_LS_FILT_CYC >= (1 << CNT_W))
   begin : g_chk_span
      $error("acc_top: CNT_W too narrow for the slowest period");
   end

   localparam logic [15:0] CTRL_OFF [2] = '{`ACC_CH0_CTRL_OFF, `ACC_CH1_CTRL_OFF};
   localparam logic [15:0] MODE_OFF [2] = '{`ACC_CH0_MODE_OFF, `ACC_CH1_MODE_OFF};

   logic [7:0] ctrl_rd [2];
   logic [15:0] mode_rd [2];
   logic [1:0] ctrl_hit;
   logic [1:0] mode_hit;
   logic [15:0] rdata_next;
   logic [15:0] rdata_reg;

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   assign rdata_next = ctrl_hit[0] ? {8'h00, ctrl_rd[0]}
      : ctrl_hit[1] ? {8'h00, ctrl_rd[1]}
      : mode_hit[0] ? mode_rd[0]
      : mode_hit[1] ? mode_rd[1]
      : 16'h0000;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= 16'h0000;
      else if (reg_rd)
         rdata_reg <= rdata_next;
      else
         rdata_reg <= 16'h0000;
   end

   assign reg_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_ch
      acc_filt_if fif ();

      acc_state_t state_reg;
      logic [4:0] ctrl_spare_reg;
      logic [15:0] mode_reg;
      logic en_reg;
      logic d_reg;
      logic rf_reg;
      logic [2:0] cnt_reg;
      logic irq_reg;
      logic trig_reg;
      logic [2:0] trdy;
      logic [1:0] cond;
      logic [1:0] fsel;
      logic ctrl_wr;
      logic mode_wr;
      logic sw_start;
      logic sw_stop;
      logic is_sup;
      logic is_mon;
      logic is_single;
      logic filt;
      logic rdy_done;
      logic end_done;
      logic measuring;
      logic rise;
      logic fall;
      logic start_ev;
      logic edge_ev;
      logic single_ev;
      logic hi_trig;
      logic lo_trig;
      logic irq_next;
      logic trig_next;
      logic [2:0] trdy_ls;
      logic [2:0] trdy_hs;
      logic start_hi;
      logic start_lo;
      logic irq_pend_reg;
      logic trig_pend_reg;
      logic irq_fire;
      logic trig_fire;

      // ---------------------------------------------------------------
      // decode
      // ---------------------------------------------------------------
      assign ctrl_hit[ch] = (reg_addr == CTRL_OFF[ch]);
      assign mode_hit[ch] = (reg_addr == MODE_OFF[ch]);
      assign ctrl_wr = reg_wr && ctrl_hit[ch];
      assign mode_wr = reg_wr && mode_hit[ch] && !en_reg;
      assign sw_start = ctrl_wr && reg_wdata[`ACC_CTRL_EN_BIT] && !en_reg;
      assign sw_stop = ctrl_wr && !reg_wdata[`ACC_CTRL_EN_BIT];
      assign ctrl_rd[ch] = {ctrl_spare_reg, rf_reg, d_reg, en_reg};
      assign mode_rd[ch] = mode_reg;

      // ---------------------------------------------------------------
      // mode fields
      // ---------------------------------------------------------------
      assign cond = mode_reg[`ACC_MODE_COND_LSB +: 2];
      assign fsel = mode_reg[`ACC_MODE_FSEL_LSB +: 2];
      assign is_sup = fsel[1];
      assign is_mon = (fsel == 2'h1);
      assign is_single = (fsel == 2'h0);

      // ---------------------------------------------------------------
      // clock and filter stage
      // ---------------------------------------------------------------
      assign fif.clk_sel = mode_reg[`ACC_MODE_CK_BIT];
      assign fif.smp_sel = mode_reg[`ACC_MODE_SMP_LSB +: 2];
      assign fif.stop_mode = stop_mode;
      assign fif.restart = sw_start;
      assign filt = fif.filt_out;

      acc_filter #(
         .CNT_W(CNT_W)
      ) u_filter (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .analog_compare_out(analog_compare_out[ch]),
         .fif(fif.filt)
      );

      // ---------------------------------------------------------------
      // ready delay in operating ticks
      // ---------------------------------------------------------------
      assign trdy_ls = fif.filt_on ? `ACC_TRDY_LS_F : `ACC_TRDY_LS_NF;
      assign trdy_hs = !fif.filt_on ? `ACC_TRDY_HS_NF
         : fif.smp_sel[0] ? `ACC_TRDY_HS128 : `ACC_TRDY_HS64;
      assign trdy = fif.clk_sel ? trdy_hs : trdy_ls;

      // ---------------------------------------------------------------
      // sequence events
      // ---------------------------------------------------------------
      assign rdy_done = (state_reg == ACC_WAIT_RDY) && fif.phi_tick && !sw_stop
         && (cnt_reg == trdy - 3'h1);
      assign end_done = (state_reg == ACC_WAIT_END) && fif.phi_tick;
      assign measuring = (state_reg == ACC_MEASURE) && !sw_stop;
      assign rise = measuring && filt && !d_reg;
      assign fall = measuring && !filt && d_reg;

      // ---------------------------------------------------------------
      // interrupt conditions
      // ---------------------------------------------------------------
      assign start_hi = rdy_done && filt;
      assign start_lo = rdy_done && !filt;
      assign start_ev = is_sup
         && (((cond == 2'h1) && start_lo) || (cond[1] && start_hi));
      assign edge_ev = ((cond == 2'h1) && fall)
         || ((cond == 2'h2) && rise)
         || ((cond == 2'h3) && (rise || fall));
      assign single_ev = rdy_done
         && ((is_single && (cond[1] == filt)) || is_mon);
      assign irq_next = start_ev || edge_ev || single_ev;

      // ---------------------------------------------------------------
      // trigger follows the condition setting
      // ---------------------------------------------------------------
      assign hi_trig = is_sup && (start_hi || rise);
      assign lo_trig = is_sup && (start_lo || fall);
      assign trig_next = (cond == 2'h1) ? lo_trig
         : (cond == 2'h3) ? (hi_trig || lo_trig) : hi_trig;

      // ---------------------------------------------------------------
      // pulse spacing, back to back events stay separate pulses
      // ---------------------------------------------------------------
      assign irq_fire = (irq_next || irq_pend_reg) && !irq_reg;
      assign trig_fire = (trig_next || trig_pend_reg) && !trig_reg;

      // ---------------------------------------------------------------
      // registers
      // ---------------------------------------------------------------
      always_ff @(posedge core_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            ctrl_spare_reg <= 5'(`ACC_CTRL_RST >> 3);
            mode_reg <= `ACC_MODE_RST;
         end
         else
         begin
            if (ctrl_wr)
               ctrl_spare_reg <= reg_wdata[7:3];
            if (mode_wr)
               mode_reg <= reg_wdata;
         end
      end

      // ---------------------------------------------------------------
      // measurement sequence
      // ---------------------------------------------------------------
      always_ff @(posedge core_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            state_reg <= ACC_IDLE;
            en_reg <= 1'b0;
            cnt_reg <= 3'h0;
         end
         else
         begin
            case (state_reg)
               ACC_IDLE:
               begin
                  if (sw_start)
                  begin
                     state_reg <= ACC_WAIT_RDY;
                     en_reg <= 1'b1;
                     cnt_reg <= 3'h0;
                  end
               end
               ACC_WAIT_RDY:
               begin
                  if (sw_stop)
                  begin
                     state_reg <= ACC_IDLE;
                     en_reg <= 1'b0;
                  end
                  else if (rdy_done)
                     state_reg <= is_sup ? ACC_MEASURE : ACC_WAIT_END;
                  else if (fif.phi_tick)
                     cnt_reg <= cnt_reg + 3'h1;
               end
               ACC_MEASURE:
               begin
                  if (sw_stop)
                  begin
                     state_reg <= ACC_IDLE;
                     en_reg <= 1'b0;
                  end
               end
               ACC_WAIT_END:
               begin
                  if (sw_stop || end_done)
                  begin
                     state_reg <= ACC_IDLE;
                     en_reg <= 1'b0;
                  end
               end
               default:
               begin
                  state_reg <= ACC_IDLE;
                  en_reg <= 1'b0;
               end
            endcase
         end
      end

      // ---------------------------------------------------------------
      // result, valid flag and event pulses
      // ---------------------------------------------------------------
      always_ff @(posedge core_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            d_reg <= 1'b0;
            rf_reg <= 1'b0;
            irq_reg <= 1'b0;
            trig_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
            trig_pend_reg <= 1'b0;
         end
         else
         begin
            if (sw_start)
               rf_reg <= 1'b0;
            else if (rdy_done)
               rf_reg <= 1'b1;
            if (rdy_done || measuring)
               d_reg <= filt;
            irq_reg <= irq_fire;
            trig_reg <= trig_fire;
            irq_pend_reg <= !sw_stop
               && (irq_reg ? (irq_next || irq_pend_reg) : (irq_next && irq_pend_reg));
            trig_pend_reg <= !sw_stop
               && (trig_reg ? (trig_next || trig_pend_reg) : (trig_next && trig_pend_reg));
         end
      end

      // ---------------------------------------------------------------
      // outputs
      // ---------------------------------------------------------------
      assign judge_irq[ch] = irq_reg;
      assign trigger_out[ch] = trig_reg;
   end
endmodule : acc_top

// ---- acc_monitor.sv ----
// port assertions for the comparator control
`timescale 1ns/1ns
module acc_monitor
#(
   parameter int CNT_W = 12
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // system and events
   input wire logic stop_mode,
   input wire logic [1:0] analog_compare_out,
   input wire logic [1:0] judge_irq,
   input wire logic [1:0] trigger_out
);
   // ---------------------------------------------------------------
   // decode and properties
   // ---------------------------------------------------------------
   wire logic ctl_w = reg_addr == 16'hF920 || reg_addr == 16'hF928;
   wire logic map_w = ctl_w || reg_addr == 16'hF922 || reg_addr == 16'hF92A;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (reg_rd && !map_w |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   ctrl_width_a: assert property (reg_rd && ctl_w |=> reg_rdata[15:8] == 8'h00)
      else $error("control read wider than a byte");
   ctrl0_back_a: assert property (reg_wr && reg_addr == 16'hF920 ##1 reg_rd &&
      reg_addr == 16'hF920 |=> reg_rdata[0] == $past(reg_wdata[0], 2) &&
      reg_rdata[7:3] == $past(reg_wdata[7:3], 2))
      else $error("channel 0 control readback wrong");
   ctrl1_back_a: assert property (reg_wr && reg_addr == 16'hF928 ##1 reg_rd &&
      reg_addr == 16'hF928 |=> reg_rdata[0] == $past(reg_wdata[0], 2))
      else $error("channel 1 control readback wrong");
   irq_pulse_a: assert property ((judge_irq & $past(judge_irq)) == 2'b00)
      else $error("interrupt longer than one cycle");
   trig_pulse_a: assert property ((trigger_out & $past(trigger_out)) == 2'b00)
      else $error("trigger longer than one cycle");
   stop_quiet_a: assert property (reg_wr && reg_addr == 16'hF920 && !reg_wdata[0]
      |=> ##1 !judge_irq[0] [*3])
      else $error("interrupt after stop");
endmodule : acc_monitor
bind acc_top acc_monitor #(.CNT_W(CNT_W)) mon_u (.core_clk(core_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .stop_mode(stop_mode), .analog_compare_out(analog_compare_out),
   .judge_irq(judge_irq), .trigger_out(trigger_out));

// ---- acc_core_model.sv ----
// behavioural comparator cores for both channels
`timescale 1ns/1ns
module acc_core_model
(
   // requested input relation
   input wire logic [1:0] pos_above_neg,
   input wire logic slow,
   // raw outputs
   output logic [1:0] analog_compare_out
);
   initial
   begin
      analog_compare_out = 2'b00;
   end
   // settle promptly or slowly after a change
   always @(pos_above_neg)
   begin
      analog_compare_out <= #(slow ? 700 : 30) pos_above_neg;
   end
endmodule : acc_core_model

// ---- tb_top.sv ----
// self-checking bench for the comparator control
`timescale 1ns/1ns
`include "acc_regs.svh"
module tb_top
   import acc_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic stop_mode = 1'b0;
   logic [1:0] level = 2'b00;
   logic slow = 1'b0;
   logic [15:0] reg_rdata;
   logic [1:0] analog_compare_out;
   logic [1:0] judge_irq;
   logic [1:0] trigger_out;
   int miscompares = 0;
   int check_count = 0;
   int irq_cnt [2] = '{0, 0};
   int trg_cnt [2] = '{0, 0};
   int seed = 32'h8FA223E3;
   always #10 core_clk = !core_clk;
   acc_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .stop_mode(stop_mode), .analog_compare_out(analog_compare_out),
      .judge_irq(judge_irq), .trigger_out(trigger_out));
   acc_core_model core_u (.pos_above_neg(level), .slow(slow),
      .analog_compare_out(analog_compare_out));
   // ---------------------------------------------------------------
   // event counting and tasks
   // ---------------------------------------------------------------
   always @(negedge core_clk)
   begin
      for (int k = 0; k < 2; k++)
      begin
         irq_cnt[k] += (judge_irq[k] === 1'b1) ? 1 : 0;
         trg_cnt[k] += (trigger_out[k] === 1'b1) ? 1 : 0;
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   function automatic int events(input logic [1:0] cnd, input logic lv, input int tog);
      int k;
      logic v;
      k = (cnd == 2'b01) ? int'(!lv) : (cnd[1] ? int'(lv) : 0);
      v = lv;
      for (int j = 0; j < tog; j++)
      begin
         v = !v;
         k += (cnd == 2'b11 || (cnd == 2'b10 && v) || (cnd == 2'b01 && !v)) ? 1 : 0;
      end
      return k;
   endfunction : events
   task automatic run(input int c, input logic [15:0] m, input logic lv, input int tog);
      logic [15:0] ca;
      logic [15:0] d;
      logic v;
      int i0;
      int t0;
      int n;
      int wt;
      ca = `ACC_CH0_CTRL_OFF + 16'(c * 8);
      wt = (m[12] && (!m[9] || stop_mode)) ? 300 : (m[12] ? 900 : 6300);
      v = lv;
      slow <= c[0];
      level[c] <= lv;
      wr(ca + 16'h0002, m);
      repeat (wt) @(posedge core_clk);
      i0 = irq_cnt[c];
      t0 = trg_cnt[c];
      wr(ca, 16'h0001);
      rd(ca, d);
      check("start", d & 16'h0005, 16'h0001);
      n = 0;
      do
      begin
         rd(ca, d);
         n++;
      end
      while (d[2] !== 1'b1 && n < 12000);
      check("ready", {15'h0, d[2]}, 16'h0001);
      check("result", {15'h0, d[1]}, {15'h0, lv});
      if (m[5])
      begin
         wr(ca + 16'h0002, ~m);
         rd(ca + 16'h0002, d);
         check("mode held", d, m);
         for (int j = 0; j < tog; j++)
         begin
            repeat (wt) @(posedge core_clk);
            v = !v;
            level[c] <= v;
         end
         repeat (wt) @(posedge core_clk);
         rd(ca, d);
         check("running", d & 16'h0007, {13'h0, 1'b1, v, 1'b1});
         check("irq", 16'(irq_cnt[c] - i0), 16'(events(m[1:0], lv, tog)));
         check("trig", 16'(trg_cnt[c] - t0), (m[1:0] == 2'b11) ? 16'(1 + tog)
            : 16'(events((m[1:0] == 2'b00) ? 2'b10 : m[1:0], lv, tog)));
         wr(ca, 16'h0000);
         level[c] <= !v;
         repeat (wt) @(posedge core_clk);
         rd(ca, d);
         check("held", d & 16'h0003, {14'h0, v, 1'b0});
      end
      else
      begin
         do
         begin
            rd(ca, d);
            n++;
         end
         while (d[0] !== 1'b0 && n < 24000);
         check("stopped", d & 16'h0007, 16'h0004 | {14'h0, lv, 1'b0});
         check("irq", 16'(irq_cnt[c] - i0), (m[4] || lv == m[1]) ? 16'h1 : 16'h0);
         check("trig", 16'(trg_cnt[c] - t0), 16'h0000);
      end
      $display("test ch %0d mode %h done", c, m);
   endtask : run
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      #1800000;
      miscompares++;
      end_of_test();
   end
   initial
   begin
      logic [15:0] d;
      logic [15:0] r;
      logic [15:0] a;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 2; c++)
      begin
         a = `ACC_CH0_CTRL_OFF + 16'(c * 8);
         rd(a, d);
         check("ctrl reset", d, 16'h0000);
         rd(a + 16'h0002, d);
         check("mode reset", d, 16'h0000);
         r = 16'($random(seed));
         wr(a, r & 16'h00F8);
         rd(a, d);
         check("ctrl store", d, r & 16'h00F8);
         wr(a + 16'h0002, r);
         rd(a + 16'h0002, d);
         check("mode store", d, r);
      end
      rd(16'hF924, d);
      check("unmapped", d, 16'h0000);
      $display("test registers done");
      for (int c = 0; c < 2; c++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            run(c, 16'h1020 | 16'(i), i[0], 2);
            run(c, 16'h1000 | 16'(i), 1'($random(seed)), 0);
         end
      end
      run(0, 16'h1012, 1'b0, 0);
      run(1, 16'h1222, 1'b1, 1);
      run(0, 16'h1323, 1'b0, 1);
      stop_mode <= 1'b1;
      run(0, 16'h1323, 1'b1, 1);
      stop_mode <= 1'b0;
      run(1, 16'h0121, 1'b1, 1);
      end_of_test();
   end
endmodule : tb_top
